/* rtl/tcso_top.sv */
// Purpose: Status flags, output selects and interrupts of an 8-bit event timer
// Assumes: Counter value arrives synchronous to CLK from the counter logic
// Notes: Constants A and B are held here; the counter itself lives outside
`include "tcso_params.svh"
`timescale 1ns/1ps
module tcso_top import tcso_pkg::*; (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic [7:0] COUNT_VAL,
    output logic WAVE_OUT,
    output logic CMP_A_STB,
    output logic CMP_B_STB,
    output logic OVF_STB,
    output logic IRQ_CMP_A,
    output logic IRQ_CMP_B,
    output logic IRQ_OVF,
    output logic IRQ
);

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    logic sel_stat;
    logic sel_ca;
    logic sel_cb;
    logic sel_en;
    logic sel_ist;
    logic wr_stat;
    logic rd_stat;
    logic wr_ca;
    logic wr_cb;
    logic wr_en;
    logic wr_ist;

    always_comb begin
        sel_stat = 1'b0;
        sel_ca = 1'b0;
        sel_cb = 1'b0;
        sel_en = 1'b0;
        sel_ist = 1'b0;
        if (ADDR == `TCSO_ADDR_STATUS) begin
            sel_stat = 1'b1;
        end else if (ADDR == `TCSO_ADDR_CONST_A) begin
            sel_ca = 1'b1;
        end else if (ADDR == `TCSO_ADDR_CONST_B) begin
            sel_cb = 1'b1;
        end else if (ADDR == `TCSO_ADDR_IRQ_EN) begin
            sel_en = 1'b1;
        end else if (ADDR == `TCSO_ADDR_IRQ_STAT) begin
            sel_ist = 1'b1;
        end
        wr_stat = WR && sel_stat;
        rd_stat = RD && sel_stat;
        wr_ca = WR && sel_ca;
        wr_cb = WR && sel_cb;
        wr_en = WR && sel_en;
        wr_ist = WR && sel_ist;
    end

    // ----------------------------------------
    // Constant registers
    // ----------------------------------------
    tcso_byte_t const_a_q;
    tcso_byte_t const_a_d;
    tcso_byte_t const_b_q;
    tcso_byte_t const_b_d;

    always_comb begin
        const_a_d = const_a_q;
        const_b_d = const_b_q;
        if (wr_ca) begin
            const_a_d = WDATA;
        end
        if (wr_cb) begin
            const_b_d = WDATA;
        end
    end

    // Reset high so a counter resting at zero after reset never matches
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            const_a_q <= `TCSO_RST_CONST;
            const_b_q <= `TCSO_RST_CONST;
        end else begin
            const_a_q <= const_a_d;
            const_b_q <= const_b_d;
        end
    end

    // ----------------------------------------
    // Output selects
    // ----------------------------------------
    logic [1:0] osel_a_q;
    logic [1:0] osel_a_d;
    logic [1:0] osel_b_q;
    logic [1:0] osel_b_d;

    always_comb begin
        osel_a_d = osel_a_q;
        osel_b_d = osel_b_q;
        if (wr_stat) begin
            // Reserved bit 4 is not stored, so writes to it vanish
            osel_b_d = WDATA[`TCSO_SEL_B_HI:`TCSO_SEL_B_LO];
            osel_a_d = WDATA[`TCSO_SEL_A_HI:`TCSO_SEL_A_LO];
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            osel_a_q <= `TCSO_RST_SEL;
            osel_b_q <= `TCSO_RST_SEL;
        end else begin
            osel_a_q <= osel_a_d;
            osel_b_q <= osel_b_d;
        end
    end

    // ----------------------------------------
    // Interrupt enables
    // ----------------------------------------
    logic [`TCSO_NUM_EV-1:0] irq_en_q;
    logic [`TCSO_NUM_EV-1:0] irq_en_d;

    always_comb begin
        irq_en_d = irq_en_q;
        if (wr_en) begin
            irq_en_d = WDATA[`TCSO_NUM_EV-1:0];
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            irq_en_q <= `TCSO_RST_EV;
        end else begin
            irq_en_q <= irq_en_d;
        end
    end

    // ----------------------------------------
    // Match and overflow detection
    // ----------------------------------------
    // Matches are edges of equality so a slowly clocked counter that
    // rests on the constant for many cycles toggles the output once.
    logic eq_a;
    logic eq_b;
    logic eq_a_q;
    logic eq_a_d;
    logic eq_b_q;
    logic eq_b_d;
    tcso_byte_t cnt_q;
    tcso_byte_t cnt_d;
    logic [`TCSO_NUM_EV-1:0] ev;

    always_comb begin
        // Comparison paused while constant A is being written
        eq_a = (COUNT_VAL == const_a_q) && !wr_ca;
        eq_b = (COUNT_VAL == const_b_q);
        eq_a_d = eq_a;
        eq_b_d = eq_b;
        cnt_d = COUNT_VAL;
        ev = '0;
        ev[`TCSO_EV_CMP_A] = eq_a && !eq_a_q;
        ev[`TCSO_EV_CMP_B] = eq_b && !eq_b_q;
        ev[`TCSO_EV_OVF] = (cnt_q == `TCSO_COUNT_MAX) &&
                           (COUNT_VAL == `TCSO_COUNT_MIN);
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            eq_a_q <= 1'b0;
            eq_b_q <= 1'b0;
            cnt_q <= `TCSO_RST_COUNT;
        end else begin
            eq_a_q <= eq_a_d;
            eq_b_q <= eq_b_d;
            cnt_q <= cnt_d;
        end
    end

    assign CMP_A_STB = ev[`TCSO_EV_CMP_A];
    assign CMP_B_STB = ev[`TCSO_EV_CMP_B];
    assign OVF_STB = ev[`TCSO_EV_OVF];

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    logic [`TCSO_NUM_EV-1:0] flag;
    logic [`TCSO_NUM_EV-1:0] flag_wbit;

    always_comb begin
        flag_wbit = '0;
        flag_wbit[`TCSO_EV_CMP_A] = WDATA[`TCSO_BIT_CMF_A];
        flag_wbit[`TCSO_EV_CMP_B] = WDATA[`TCSO_BIT_CMF_B];
        flag_wbit[`TCSO_EV_OVF] = WDATA[`TCSO_BIT_OVF];
    end

    logic [`TCSO_NUM_EV-1:0] ist_q;
    logic [`TCSO_NUM_EV-1:0] irq_src;

    genvar gi;
    generate
        for (gi = 0; gi < `TCSO_NUM_EV; gi = gi + 1) begin : g_flag
            logic ist_bit_q;
            logic ist_bit_d;

            tcso_flag u_flag (
                .clk(CLK),
                .arst_n(ARST_N),
                .set(ev[gi]),
                .rd(rd_stat),
                .wr(wr_stat),
                .wbit(flag_wbit[gi]),
                .flag_q(flag[gi])
            );

            // Summary status copy; a set beats a same-cycle write-one clear
            always_comb begin
                ist_bit_d = ist_bit_q;
                if (ev[gi]) begin
                    ist_bit_d = 1'b1;
                end else if (wr_ist && WDATA[gi]) begin
                    ist_bit_d = 1'b0;
                end
            end

            always_ff @(posedge CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    ist_bit_q <= 1'b0;
                end else begin
                    ist_bit_q <= ist_bit_d;
                end
            end

            assign ist_q[gi] = ist_bit_q;
            // Source request needs the flag and its enable together
            assign irq_src[gi] = flag[gi] && irq_en_q[gi];
        end
    endgenerate

    // ----------------------------------------
    // Waveform output
    // ----------------------------------------
    tcso_wave u_wave (
        .clk(CLK),
        .arst_n(ARST_N),
        .match_a(ev[`TCSO_EV_CMP_A]),
        .match_b(ev[`TCSO_EV_CMP_B]),
        .sel_a(osel_a_q),
        .sel_b(osel_b_q),
        .wave_q(WAVE_OUT)
    );

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    // Per-source requests follow the status flags; the summary line
    // uses its own sticky copy so clearing one does not hide the other.
    assign IRQ_CMP_A = irq_src[`TCSO_EV_CMP_A];
    assign IRQ_CMP_B = irq_src[`TCSO_EV_CMP_B];
    assign IRQ_OVF = irq_src[`TCSO_EV_OVF];
    // Level line: high while any enabled summary bit is pending
    assign IRQ = |(ist_q & irq_en_q);

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    tcso_byte_t rdata_d;
    tcso_byte_t rdata_q;

    always_comb begin
        rdata_d = '0;
        if (RD) begin
            if (sel_stat) begin
                rdata_d[`TCSO_BIT_CMF_B] = flag[`TCSO_EV_CMP_B];
                rdata_d[`TCSO_BIT_CMF_A] = flag[`TCSO_EV_CMP_A];
                rdata_d[`TCSO_BIT_OVF] = flag[`TCSO_EV_OVF];
                rdata_d[`TCSO_BIT_RSVD] = `TCSO_RSVD_VAL;
                rdata_d[`TCSO_SEL_B_HI:`TCSO_SEL_B_LO] = osel_b_q;
                rdata_d[`TCSO_SEL_A_HI:`TCSO_SEL_A_LO] = osel_a_q;
            end else if (sel_ca) begin
                rdata_d = const_a_q;
            end else if (sel_cb) begin
                rdata_d = const_b_q;
            end else if (sel_en) begin
                rdata_d[`TCSO_NUM_EV-1:0] = irq_en_q;
            end else if (sel_ist) begin
                rdata_d[`TCSO_NUM_EV-1:0] = ist_q;
            end
        end
    end

    // Data stand only in the cycle after the read strobe
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign RDATA = rdata_q;

endmodule

/* inc/tcso_params.svh */
// Purpose: Offsets, field positions and reset values of the timer status/output block
// Assumes: 8-bit register port, word index equals address
// Notes: Used only by the top module; the flag and wave modules do not use it
`ifndef TCSO_PARAMS_SVH
`define TCSO_PARAMS_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define TCSO_ADDR_W 3
`define TCSO_ADDR_STATUS 3'h0
`define TCSO_ADDR_CONST_A 3'h1
`define TCSO_ADDR_CONST_B 3'h2
`define TCSO_ADDR_IRQ_EN 3'h3
`define TCSO_ADDR_IRQ_STAT 3'h4

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TCSO_BIT_CMF_B 7
`define TCSO_BIT_CMF_A 6
`define TCSO_BIT_OVF 5
`define TCSO_BIT_RSVD 4
`define TCSO_SEL_B_HI 3
`define TCSO_SEL_B_LO 2
`define TCSO_SEL_A_HI 1
`define TCSO_SEL_A_LO 0
`define TCSO_EV_CMP_A 0
`define TCSO_EV_CMP_B 1
`define TCSO_EV_OVF 2
`define TCSO_NUM_EV 3

// ----------------------------------------
// Reset and fixed values
// ----------------------------------------
`define TCSO_RST_CONST 8'hff
`define TCSO_RST_COUNT 8'h00
`define TCSO_RST_SEL 2'h0
`define TCSO_RST_EV 3'h0
`define TCSO_COUNT_MAX 8'hff
`define TCSO_COUNT_MIN 8'h00
`define TCSO_RSVD_VAL 1'b1

`endif

/* inc/tcso_pkg.sv */
// Purpose: Types of the timer status/output block
// Assumes: Constants live in tcso_params.svh
// Notes: Output select codes match the register field encoding
package tcso_pkg;

    typedef enum logic [1:0] {
        TCSO_OS_KEEP   = 2'h0,
        TCSO_OS_LOW    = 2'h1,
        TCSO_OS_HIGH   = 2'h2,
        TCSO_OS_TOGGLE = 2'h3
    } tcso_osel_t;

    typedef logic [7:0] tcso_byte_t;

endpackage

/* rtl/tcso_flag.sv */
// Purpose: One status flag with read-one-then-write-zero clearing
// Assumes: Read and write strobes never coincide
// Notes: A set in the clearing cycle wins
`timescale 1ns/1ps
module tcso_flag import tcso_pkg::*; (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic set,
    input wire logic rd,
    input wire logic wr,
    input wire logic wbit,
    output logic flag_q
);
    logic flag_d;
    logic armed_q;
    logic armed_d;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        flag_d = flag_q;
        armed_d = armed_q;
        if (rd && flag_q) begin
            armed_d = 1'b1;
        end else if (wr) begin
            armed_d = 1'b0;
        end
        if (set) begin
            flag_d = 1'b1;
        end else if (wr && !wbit && armed_q) begin
            // Writing one never changes the flag
            flag_d = 1'b0;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flag_q <= 1'b0;
            armed_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
            armed_q <= armed_d;
        end
    end
endmodule

/* rtl/tcso_wave.sv */
// Purpose: Waveform output driven by compare matches
// Assumes: Match inputs are one-cycle events
// Notes: Match B action is applied to the result of match A when both matches coincide
`timescale 1ns/1ps
module tcso_wave import tcso_pkg::*; (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic match_a,
    input wire logic match_b,
    input wire logic [1:0] sel_a,
    input wire logic [1:0] sel_b,
    output logic wave_q
);
    logic wave_d;
    logic after_a;
    tcso_osel_t mode_a;
    tcso_osel_t mode_b;

    // ----------------------------------------
    // Function of one select field
    // ----------------------------------------
    function automatic logic apply(input tcso_osel_t m, input logic cur);
        logic r;
        case (m)
            TCSO_OS_LOW: r = 1'b0;
            TCSO_OS_HIGH: r = 1'b1;
            TCSO_OS_TOGGLE: r = ~cur;
            default: r = cur;
        endcase
        return r;
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        mode_a = tcso_osel_t'(sel_a);
        mode_b = tcso_osel_t'(sel_b);
        after_a = match_a ? apply(mode_a, wave_q) : wave_q;
        // B applied on top of A's result when both match
        wave_d = match_b ? apply(mode_b, after_a) : after_a;
    end

    // ----------------------------------------
    // Register
    // ----------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wave_q <= 1'b0;
        end else begin
            wave_q <= wave_d;
        end
    end
endmodule

/* tb/tcso_top_props.sv */
// Purpose: Port checker for tcso_top
// Assumes: Select shadow follows status writes
// Notes: Bound to the top module at the foot of this file
`timescale 1ns/1ps
module tcso_props import tcso_pkg::*; (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic [7:0] COUNT_VAL,
    input wire logic WAVE_OUT,
    input wire logic CMP_A_STB,
    input wire logic CMP_B_STB,
    input wire logic OVF_STB,
    input wire logic IRQ_CMP_A,
    input wire logic IRQ_CMP_B,
    input wire logic IRQ_OVF,
    input wire logic IRQ
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    logic [3:0] sel_q;
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) sel_q <= 4'h0;
        else if (WR && ADDR == 3'h0) sel_q <= WDATA[3:0];
    end
    function automatic logic nxt(input logic [1:0] s, input logic w);
        nxt = (s == 2'h0) ? w : (s == 2'h1) ? 1'b0 : (s == 2'h2) ? 1'b1 : ~w;
    endfunction
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    sequence s_rd_st; RD && ADDR == 3'h0; endsequence
    sequence s_only_a; CMP_A_STB && !CMP_B_STB; endsequence
    sequence s_only_b; CMP_B_STB && !CMP_A_STB; endsequence
    sequence s_en_wr; WR && ADDR == 3'h3; endsequence
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_cmpa_wr; (WR && ADDR == 3'h1) |-> !CMP_A_STB; endproperty
    property p_ovf; OVF_STB == (COUNT_VAL == 8'h00 && $past(COUNT_VAL) == 8'hff); endproperty
    property p_rsvd; s_rd_st |=> RDATA[4]; endproperty
    property p_wave_a;
        s_only_a |=> WAVE_OUT == nxt($past(sel_q[1:0]), $past(WAVE_OUT));
    endproperty
    property p_wave_b;
        s_only_b |=> WAVE_OUT == nxt($past(sel_q[3:2]), $past(WAVE_OUT));
    endproperty
    property p_wave_ab;
        CMP_A_STB && CMP_B_STB |=>
            WAVE_OUT == nxt($past(sel_q[3:2]), nxt($past(sel_q[1:0]), $past(WAVE_OUT)));
    endproperty
    property p_wave_hold; !CMP_A_STB && !CMP_B_STB |=> $stable(WAVE_OUT); endproperty
    property p_irq_a;
        $rose(IRQ_CMP_A) |-> $past(CMP_A_STB) || $past(WR && ADDR == 3'h3);
    endproperty
    property p_irq_b;
        $rose(IRQ_CMP_B) |-> $past(CMP_B_STB) || $past(WR && ADDR == 3'h3);
    endproperty
    property p_irq_o;
        $rose(IRQ_OVF) |-> $past(OVF_STB) || $past(WR && ADDR == 3'h3);
    endproperty
    property p_irq_off;
        s_en_wr ##0 (WDATA[2:0] == 3'h0) |=> !IRQ_CMP_A && !IRQ_CMP_B && !IRQ_OVF && !IRQ;
    endproperty
    property p_stb_a; CMP_A_STB |=> !CMP_A_STB; endproperty
    property p_stb_b; CMP_B_STB |=> !CMP_B_STB; endproperty
    a_cmpa_wr: assert property (p_cmpa_wr) else $error("compare A during write");
    a_ovf: assert property (p_ovf) else $error("overflow strobe wrong");
    a_rsvd: assert property (p_rsvd) else $error("reserved bit not one");
    a_wave_a: assert property (p_wave_a) else $error("wave after A wrong");
    a_wave_b: assert property (p_wave_b) else $error("wave after B wrong");
    a_wave_ab: assert property (p_wave_ab) else $error("wave after A and B wrong");
    a_wave_hold: assert property (p_wave_hold) else $error("wave moved");
    a_irq_a: assert property (p_irq_a) else $error("irq A without cause");
    a_irq_b: assert property (p_irq_b) else $error("irq B without cause");
    a_irq_o: assert property (p_irq_o) else $error("irq ovf without cause");
    a_irq_off: assert property (p_irq_off) else $error("irq with enables off");
    a_stb_a: assert property (p_stb_a) else $error("match A strobe too long");
    a_stb_b: assert property (p_stb_b) else $error("match B strobe too long");
endmodule

bind tcso_top tcso_props u_tcso_props (.CLK, .ARST_N, .ADDR, .WDATA, .WR, .RD, .RDATA,
    .COUNT_VAL, .WAVE_OUT, .CMP_A_STB, .CMP_B_STB, .OVF_STB, .IRQ_CMP_A, .IRQ_CMP_B,
    .IRQ_OVF, .IRQ);

/* tb/tb_tcso_top.sv */
// Purpose: Self-checking bench for tcso_top
// Assumes: Read data valid in the cycle after the strobe
// Notes: Constants and selects drawn from seed 23
`timescale 1ns/1ps
module tb_tcso_top import tcso_pkg::*; ;
    logic CLK, WAVE_OUT, CMP_A_STB, CMP_B_STB, OVF_STB, IRQ_CMP_A, IRQ_CMP_B, IRQ_OVF, IRQ;
    logic ARST_N = 1'b0;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [2:0] ADDR = 3'h0;
    logic [7:0] WDATA = 8'h00;
    logic [7:0] COUNT_VAL = 8'h00;
    logic [7:0] RDATA, ca, cb;
    logic [3:0] sl;
    logic w;
    int error_cnt = 0;
    int samples_checked = 0;

    tcso_top u_tcso_top (.CLK, .ARST_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .COUNT_VAL,
        .WAVE_OUT, .CMP_A_STB, .CMP_B_STB, .OVF_STB, .IRQ_CMP_A, .IRQ_CMP_B, .IRQ_OVF, .IRQ);

    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    function automatic logic nxt(input logic [1:0] s, input logic w0);
        nxt = (s == 2'h0) ? w0 : (s == 2'h1) ? 1'b0 : (s == 2'h2) ? 1'b1 : ~w0;
    endfunction
    task automatic fail(input string m);
        error_cnt++;
        $display("[FAIL] %0t %s", $time, m);
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) fail($sformatf("byte %h exp %h", g, e));
    endtask
    task automatic chk1(input logic g, input logic e);
        samples_checked++;
        if (g !== e) fail($sformatf("bit %b exp %b", g, e));
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
        #1;
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] e);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        chk8(RDATA, e);
    endtask
    task automatic cnt(input logic [7:0] v, input logic [2:0] e);
        @(posedge CLK);
        COUNT_VAL <= v;
        #1;
        chk1(CMP_A_STB, e[0]);
        chk1(CMP_B_STB, e[1]);
        chk1(OVF_STB, e[2]);
        @(posedge CLK);
        #1;
    endtask
    task automatic summarize;
        if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Watchdog: the whole run needs far fewer cycles
    initial begin
        repeat (3000) @(posedge CLK);
        fail("timeout");
        summarize;
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(23));
        repeat (5) @(posedge CLK);
        ARST_N <= 1'b1;
        rdc(3'h0, 8'h10);
        rdc(3'h3, 8'h00);
        for (int i = 5; i < 8; i++) begin
            wr(3'(i), 8'hff);
            rdc(3'(i), 8'h00);
        end
        ca = 8'h10 + 8'($urandom % 96);
        cb = ca + 8'h40;
        sl = 4'($urandom);
        wr(3'h1, ca);
        wr(3'h2, cb);
        wr(3'h3, 8'h07);
        wr(3'h0, {4'hf, sl});
        rdc(3'h0, {4'h1, sl});
        w = 1'b0;
        for (int k = 0; k < 4; k++) begin
            wr(3'h0, {4'he, 2'h0, 2'(k)});
            cnt(ca ^ 8'h01, 3'h0);
            cnt(ca, 3'h1);
            w = nxt(2'(k), w);
            chk1(WAVE_OUT, w);
            wr(3'h0, {4'he, 2'(k), 2'h0});
            cnt(cb ^ 8'h01, 3'h0);
            cnt(cb, 3'h2);
            w = nxt(2'(k), w);
            chk1(WAVE_OUT, w);
        end
        // Both matches in one cycle: B acts on the result of A
        sl = 4'he;
        wr(3'h2, ca);
        wr(3'h0, {4'he, sl});
        cnt(ca ^ 8'h01, 3'h0);
        cnt(ca, 3'h3);
        w = nxt(2'h3, nxt(2'h2, w));
        chk1(WAVE_OUT, w);
        wr(3'h2, cb);
        cnt(8'hff, 3'h0);
        cnt(8'h00, 3'h4);
        chk1(IRQ_OVF, 1'b1);
        chk1(IRQ_CMP_A, 1'b1);
        chk1(IRQ_CMP_B, 1'b1);
        wr(3'h0, {4'h0, sl});
        rdc(3'h0, {4'hf, sl});
        wr(3'h0, {4'h0, sl});
        rdc(3'h0, {4'h1, sl});
        chk1(IRQ_CMP_A, 1'b0);
        chk1(IRQ, 1'b1);
        wr(3'h4, 8'h07);
        chk1(IRQ, 1'b0);
        // Masked event still sets the flag but keeps the line low
        wr(3'h3, 8'h00);
        cnt(ca ^ 8'h01, 3'h0);
        cnt(ca, 3'h1);
        chk1(IRQ, 1'b0);
        chk1(IRQ_CMP_A, 1'b0);
        rdc(3'h4, 8'h01);
        rdc(3'h0, {4'h5, sl});
        wr(3'h3, 8'h01);
        chk1(IRQ, 1'b1);
        wr(3'h4, 8'h01);
        chk1(IRQ, 1'b0);
        wr(3'h0, {4'h0, sl});
        // Constant A written to the value the counter already holds
        cnt(8'hc0, 3'h0);
        wr(3'h1, 8'hc0);
        rdc(3'h0, {4'h5, sl});
        summarize;
    end
endmodule
